// *** core/mbag_pkg.sv ***
// Contract
// - Modulo correction works with any working register.
// - Compare up/down buffers past boundaries, not equality.
// - Write back only for pre/post modify.
// - Bit reversal only X generator, writes only.
// - Pointer and modifier are both bit reversed for the add.
// - Enable: select not 1111, enable bit, pre/post inc.
// - Pivot comes from modifier register low fifteen bits.
// - Word data, address bit zero clear, scaled modifier.
// - Other modes or byte writes give normal addresses.
// - Pointer plus reversed modifier, offset ignored, lsb zero.
// - Bit reversal beats modulo on writes.
package mbag_pkg;

	// ----------------------------------------
	// Register map and field positions.
	// ----------------------------------------
	localparam logic [4:0] MBAG_OFS_CTRL = 5'h00;
	localparam logic [4:0] MBAG_OFS_START = 5'h04;
	localparam logic [4:0] MBAG_OFS_END = 5'h08;
	localparam logic [4:0] MBAG_OFS_BREV = 5'h0c;
	localparam logic [4:0] MBAG_OFS_STAT = 5'h10;
	localparam int MBAG_REVERSE_ENABLE_BIT_BIT = 15;
	localparam logic [15:0] MBAG_RST_REG = 16'h0000;
	localparam logic [3:0] MBAG_SEL_STACK = 4'hf;
	localparam logic [1:0] MBAG_RESP_OK = 2'h0;
	localparam logic [1:0] MBAG_RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Addressing modes from the pipeline.
	// ----------------------------------------
	typedef enum logic [2:0] {
		MBAG_MODE_DIRECT = 3'b000,
		MBAG_MODE_POST_INC = 3'b001,
		MBAG_MODE_POST_DEC = 3'b010,
		MBAG_MODE_PRE_INC = 3'b011,
		MBAG_MODE_PRE_DEC = 3'b100,
		MBAG_MODE_OFFSET = 3'b101
	} mbag_mode_e;

	typedef struct packed {
		logic valid;
		logic [3:0] wreg;
		mbag_mode_e mode;
		logic is_byte;
		logic is_write;
		logic is_xagu;
		logic [15:0] ptr;
		logic [15:0] offset;
	} mbag_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] ea;
		logic wb_en;
		logic [15:0] wb_val;
		logic brev_used;
		logic mod_used;
	} mbag_rsp_s;

endpackage

// *** core/mbag_top.sv ***
`timescale 1ns/1ns
module mbag_top (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire mbag_pkg::mbag_req_s i_req,
	output mbag_pkg::mbag_rsp_s o_rsp,
	input wire logic [4:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [4:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	import mbag_pkg::*;

	// ----------------------------------------
	// Software registers.
	// ----------------------------------------
	// Control: [3:0] modulo register select, [7:4] reverse pointer select,
	// [8] modulo enable.
	logic [15:0] ctrl_q;
	logic [15:0] start_q;
	logic [15:0] end_q;
	logic [15:0] brev_q;
	logic [15:0] stat_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [4:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;

	// ----------------------------------------
	// Address generation, combinational.
	// ----------------------------------------
	logic is_inc;
	logic is_dec;
	logic is_modify;
	logic is_pre;
	logic [15:0] step;
	logic [15:0] upd;
	logic [15:0] mod_upd;
	logic mod_hit;
	logic brev_hit;
	logic [15:0] brev_ea;
	logic [15:0] pivot_rev;
	logic [15:0] ea_d;
	logic [15:0] wb_d;

	assign is_inc = (i_req.mode == MBAG_MODE_POST_INC) ||
		(i_req.mode == MBAG_MODE_PRE_INC);
	assign is_dec = (i_req.mode == MBAG_MODE_POST_DEC) ||
		(i_req.mode == MBAG_MODE_PRE_DEC);
	assign is_modify = is_inc || is_dec;
	assign is_pre = (i_req.mode == MBAG_MODE_PRE_INC) ||
		(i_req.mode == MBAG_MODE_PRE_DEC);
	assign step = i_req.is_byte ? 16'h0001 : 16'h0002;

	// Updated pointer before modulo correction.
	always_comb begin
		case (i_req.mode)
			MBAG_MODE_POST_INC, MBAG_MODE_PRE_INC: upd = i_req.ptr + step;
			MBAG_MODE_POST_DEC, MBAG_MODE_PRE_DEC: upd = i_req.ptr - step;
			MBAG_MODE_OFFSET: upd = i_req.ptr + i_req.offset;
			default: upd = i_req.ptr;
		endcase
	end

	// Modulo applies to whichever working register software selects.
	assign mod_hit = ctrl_q[8] && (i_req.wreg == ctrl_q[3:0]);

	// Wrap on passing a boundary, not on touching it; the length is
	// end - start + 1, so an overshoot keeps its distance past the edge.
	always_comb begin
		mod_upd = upd;
		if (mod_hit && (is_inc || i_req.mode == MBAG_MODE_OFFSET) &&
			(upd > end_q)) begin
			mod_upd = upd - (end_q - start_q + 16'h0001);
		end else if (mod_hit && (is_dec || i_req.mode == MBAG_MODE_OFFSET)
			&& (upd < start_q)) begin
			mod_upd = upd + (end_q - start_q + 16'h0001);
		end
	end

	// Pivot from the modifier, shifted up one bit so addresses stay word aligned.
	always_comb begin
		pivot_rev = 16'h0000;
		for (int i = 0; i < 15; i++) begin
			pivot_rev[i + 1] = brev_q[i];
		end
	end

	// Reverse-carry add: the pointer and the modifier are both reversed,
	// added, and the sum is reversed back.
	always_comb begin
		logic [15:0] pr;
		logic [15:0] sr;
		pr = 16'h0000;
		sr = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			pr[i] = i_req.ptr[15 - i];
		end
		pr = pr + {pivot_rev[0], pivot_rev[1], pivot_rev[2], pivot_rev[3],
			pivot_rev[4], pivot_rev[5], pivot_rev[6], pivot_rev[7],
			pivot_rev[8], pivot_rev[9], pivot_rev[10], pivot_rev[11],
			pivot_rev[12], pivot_rev[13], pivot_rev[14], pivot_rev[15]};
		for (int i = 0; i < 16; i++) begin
			sr[i] = pr[15 - i];
		end
		brev_ea = {sr[15:1], 1'b0};
	end

	// Only X-generator word writes in pre/post increment through the
	// chosen pointer, never the stack pointer.
	assign brev_hit = brev_q[MBAG_REVERSE_ENABLE_BIT_BIT] && (ctrl_q[7:4] != MBAG_SEL_STACK)
		&& (i_req.wreg == ctrl_q[7:4]) && is_inc && !i_req.is_byte
		&& i_req.is_write && i_req.is_xagu;

	// Bit reversal takes precedence over modulo on the same register.
	always_comb begin
		if (brev_hit) begin
			ea_d = is_pre ? brev_ea : i_req.ptr;
			wb_d = brev_ea;
		end else if (i_req.mode == MBAG_MODE_OFFSET) begin
			ea_d = mod_upd;
			wb_d = i_req.ptr;
		end else begin
			ea_d = is_pre ? mod_upd : i_req.ptr;
			wb_d = mod_upd;
		end
	end

	// Result register for the pipeline; one cycle of latency.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rsp <= '0;
		end else begin
			o_rsp.valid <= i_req.valid;
			o_rsp.ea <= ea_d;
			o_rsp.wb_en <= i_req.valid && is_modify;
			o_rsp.wb_val <= wb_d;
			o_rsp.brev_used <= i_req.valid && brev_hit;
			o_rsp.mod_used <= i_req.valid && mod_hit && !brev_hit;
		end
	end

	// Status: last effective address for software visibility.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			stat_q <= MBAG_RST_REG;
		end else if (i_req.valid) begin
			stat_q <= ea_d;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave.
	// ----------------------------------------
	// Address and data may arrive in either order; each is held until
	// both are present, and no new one is taken while a response waits.
	assign o_awready = !aw_hold_q && !o_bvalid;
	assign o_wready = !w_hold_q && !o_bvalid;
	assign do_write = aw_hold_q && w_hold_q && !o_bvalid;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= MBAG_RESP_OK;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (awaddr_q <= MBAG_OFS_BREV && awaddr_q[1:0] == 2'h0)
					? MBAG_RESP_OK : MBAG_RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Register writes honour the two low byte lanes.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= MBAG_RST_REG;
			start_q <= MBAG_RST_REG;
			end_q <= MBAG_RST_REG;
			brev_q <= MBAG_RST_REG;
		end else if (do_write) begin
			for (int b = 0; b < 2; b++) begin
				if (wstrb_q[b]) begin
					case (awaddr_q)
						MBAG_OFS_CTRL: ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						MBAG_OFS_START: start_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						MBAG_OFS_END: end_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						MBAG_OFS_BREV: brev_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						default: ;
					endcase
				end
			end
		end
	end

	// Read channel; the status word sits in the fifth aligned slot and is
	// read only, so a write to it is answered with an error.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= MBAG_RESP_OK;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp <= MBAG_RESP_OK;
			case (i_araddr)
				MBAG_OFS_CTRL: o_rdata <= {16'h0000, ctrl_q};
				MBAG_OFS_START: o_rdata <= {16'h0000, start_q};
				MBAG_OFS_END: o_rdata <= {16'h0000, end_q};
				MBAG_OFS_BREV: o_rdata <= {16'h0000, brev_q};
				MBAG_OFS_STAT: o_rdata <= {16'h0000, stat_q};
				default: begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= MBAG_RESP_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	assign o_arready = !o_rvalid;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	property p_offset_no_wb;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.mode == MBAG_MODE_OFFSET |=> !o_rsp.wb_en;
	endproperty
	a_offset_no_wb: assert property (p_offset_no_wb)
		else $error("Offset mode wrote the pointer back.");

	property p_brev_lsb;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rsp.brev_used |-> o_rsp.wb_val[0] == 1'b0;
	endproperty
	a_brev_lsb: assert property (p_brev_lsb)
		else $error("Bit reversed address has lsb set.");

	property p_brev_byte;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_req.valid && (i_req.is_byte || !i_req.is_write || !i_req.is_xagu)
		|=> !o_rsp.brev_used;
	endproperty
	a_brev_byte: assert property (p_brev_byte)
		else $error("Bit reversal on a non X word write.");

	property p_brev_mode;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_req.valid && !is_inc |=> !o_rsp.brev_used;
	endproperty
	a_brev_mode: assert property (p_brev_mode)
		else $error("Bit reversal outside increment modes.");

	property p_brev_stack;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		ctrl_q[7:4] == MBAG_SEL_STACK |=> !o_rsp.brev_used;
	endproperty
	a_brev_stack: assert property (p_brev_stack)
		else $error("Bit reversal through the stack pointer.");

	property p_priority;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_rsp.brev_used |-> !o_rsp.mod_used;
	endproperty
	a_priority: assert property (p_priority)
		else $error("Modulo and bit reversal both used.");

	property p_wrap_up;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_req.valid && mod_hit && !brev_hit && is_inc && upd > end_q
		&& start_q <= end_q |=> o_rsp.wb_val <= $past(end_q);
	endproperty
	a_wrap_up: assert property (p_wrap_up)
		else $error("Incrementing buffer not wrapped.");

	property p_bresp_after;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		do_write |=> o_bvalid;
	endproperty
	a_bresp_after: assert property (p_bresp_after)
		else $error("Write response missing.");

endmodule // mbag_top

// *** tb/mbag_pipe_model.sv ***
`timescale 1ns/1ns
module mbag_pipe_model
	import mbag_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire mbag_pkg::mbag_req_s i_cmd,
	output mbag_pkg::mbag_req_s o_req
);
	// Issue stage of the pipeline. The bench never reads through the
	// reverse pointer right after a modifier write.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_req <= '0;
		end else begin
			o_req <= i_cmd;
		end
	end
endmodule // mbag_pipe_model

// *** tb/tb_modulo_bitrev_addr_gen.sv ***
`timescale 1ns/1ns
`define CHK(n, x, g) checks++; if ((g) !== (x)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", n, x, g); end
module tb_modulo_bitrev_addr_gen;
	import mbag_pkg::*;
	localparam mbag_mode_e PI = MBAG_MODE_POST_INC;
	localparam mbag_mode_e PD = MBAG_MODE_POST_DEC;
	localparam mbag_mode_e RI = MBAG_MODE_PRE_INC;
	localparam mbag_mode_e OF = MBAG_MODE_OFFSET;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [15:0] p, e, ctl;
	mbag_req_s cmd, req;
	mbag_rsp_s rsp;
	int n_errors, checks;

	// ----------------------------------------
	// Design, issue stage and clock.
	// ----------------------------------------
	mbag_pipe_model pipe (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
		.o_req(req));
	mbag_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req),
		.o_rsp(rsp), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	// Free running system clock.
	always #5 clk = ~clk;

	// Address and data are offered together and dropped once taken.
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 100);
		r = bresp;
		if (bvalid !== 1'b1) n_errors++;
		if (a == MBAG_OFS_CTRL) ctl = v[15:0];
		bready <= 0;
	endtask

	// Read address is held until taken, rready until rvalid.
	task automatic rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata; r = rresp;
		if (rvalid !== 1'b1) n_errors++;
		rready <= 0;
	endtask

	// Issues one request; the answer stands one cycle so it is caught.
	task automatic go(input logic [3:0] w, input mbag_mode_e m,
		input logic [15:0] pt, input logic [15:0] of, input logic [2:0] f,
		input logic [15:0] ea, input logic wb, input logic [15:0] wv,
		input logic br);
		mbag_req_s q;
		int n;
		n = 0;
		q = '0;
		q.valid = 1; q.wreg = w; q.mode = m; q.ptr = pt; q.offset = of;
		{q.is_byte, q.is_write, q.is_xagu} = f;
		@(posedge clk);
		cmd <= q;
		@(posedge clk);
		cmd <= '0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (rsp.valid !== 1'b1 && n < 8);
		`CHK("ea", ea, rsp.ea)
		`CHK("wb_en", wb, rsp.wb_en)
		`CHK("wb_val", wv, rsp.wb_val)
		`CHK("brev_used", br, rsp.brev_used)
		`CHK("valid", 1'b1, rsp.valid)
		`CHK("mod_used", ctl[8] && w == ctl[3:0] && !br, rsp.mod_used)
	endtask

	// Reverse-carry add, with the address lsb forced clear.
	function automatic logic [15:0] rv(input logic [15:0] a);
		for (int i = 0; i < 16; i++) rv[i] = a[15 - i];
	endfunction
	function automatic logic [15:0] badd(input logic [15:0] a, b);
		badd = rv(rv(a) + rv(b)) & 16'hfffe;
	endfunction

	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Cuts a hung run short; all tests need far less time.
	initial begin
		#200000 n_errors++;
		close_out();
	end

	// Main test sequence.
	initial begin
		clk = 0; rst_n = 0; cmd = '0; awaddr = 0; araddr = 0; wdata = 0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		n_errors = 0; checks = 0;
		ctl = 16'h0000;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 20; i += 4) begin
			rd(i[4:0]);
			`CHK("reset", {MBAG_RESP_OK, 32'h0}, {r, d})
		end
		wr(MBAG_OFS_BREV, 32'h8008);
		rd(MBAG_OFS_BREV);
		`CHK("brev", 32'h8008, d)
		wr(5'h0e, 32'h1);
		`CHK("bresp", MBAG_RESP_SLVERR, r)
		rd(5'h0e);
		`CHK("rresp", {MBAG_RESP_SLVERR, 32'h0}, {r, d})
		$display("test registers done");
		wr(MBAG_OFS_START, 32'h1000);
		wr(MBAG_OFS_END, 32'h100f);
		for (int s = 3; s < 16; s += 12) begin
			wr(MBAG_OFS_CTRL, 32'h100 | s);
			go(s, PI, 16'h100e, 4, 3'b010, 16'h100e, 1, 16'h1000, 0);
			go(s, PD, 16'h1000, 4, 3'b010, 16'h1000, 1, 16'h100e, 0);
			go(s, RI, 16'h100e, 2, 3'b010, 16'h1000, 1, 16'h1000, 0);
			go(s, RI, 16'h1004, 2, 3'b010, 16'h1006, 1, 16'h1006, 0);
			go(s, OF, 16'h100c, 8, 3'b010, 16'h1004, 0, 16'h100c, 0);
			go(s ^ 1, PI, 16'h100e, 4, 3'b010, 16'h100e, 1, 16'h1010, 0);
		end
		$display("test modulo done");
		wr(MBAG_OFS_CTRL, 32'h122);
		p = 16'h2000;
		for (int k = 0; k < 4; k++) begin
			e = badd(p, 16'h0010);
			go(2, PI, p, 2, 3'b011, p, 1, e, 1);
			p = e;
		end
		e = badd(16'h2000, 16'h0010);
		go(2, RI, 16'h2001, 2, 3'b011, e, 1, e, 1);
		$display("test reverse done");
		wr(MBAG_OFS_CTRL, 32'h20);
		p = 16'h2000;
		go(2, PI, p, 2, 3'b111, p, 1, 16'h2001, 0);
		go(2, PI, p, 2, 3'b001, p, 1, 16'h2002, 0);
		go(2, PI, p, 2, 3'b010, p, 1, 16'h2002, 0);
		go(2, PD, p, 2, 3'b011, p, 1, 16'h1ffe, 0);
		go(2, OF, p, 2, 3'b011, 16'h2002, 0, p, 0);
		go(3, PI, p, 2, 3'b011, p, 1, 16'h2002, 0);
		wr(MBAG_OFS_CTRL, 32'hf0);
		go(15, PI, p, 2, 3'b011, p, 1, 16'h2002, 0);
		wr(MBAG_OFS_CTRL, 32'h20);
		wr(MBAG_OFS_BREV, 32'h0008);
		go(2, PI, p, 2, 3'b011, p, 1, 16'h2002, 0);
		rd(MBAG_OFS_STAT);
		`CHK("status", {MBAG_RESP_OK, 32'h2000}, {r, d})
		$display("test normal done");
		close_out();
	end
endmodule // tb_modulo_bitrev_addr_gen
